/* dpi_ctrl.sv */
// controller end: power-up sequencer with wishbone register slave
//
// Our own choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`include "dpi_defs.svh"
// Functional notes
// - dram has eight banks, bank address selects
// - page size is 2^colbits times width/8
// - 8n prefetch, two words per clock
// - bursts of eight or chopped four, ordered
// - activate opens bank/row, read/write gives column
// - A10 auto precharge, A12 chop if on-the-fly
// - power-up reset held at least 200us
// - cke low 10ns before reset release
// - wait 500us after release before cke
// - clock stable max(10ns,5tCK) before cke
// - nop registered before cke rises
// - cke stays high through init end
// - dram termination off until cke registered
// - odt held static low during init
// - wait tXPR before first mode load
// - load MR2 then MR3 with bank selects
// - load MR1 with DLL enabled, A0 low
// - load MR0 with DLL reset, A8 high
// - long zq, then wait lock and calibration
// - warm reset 100ns, then repeat sequence
// - precharge A10 low one bank, high all
module dpi_ctrl
  import dpi_pkg::*;
#(
  parameter int P_RST_PWR_CYC = `T_RST_PWR_US * `CLK_MHZ,  // 200us hold
  parameter int P_RST_CKE_CYC = `T_RST_CKE_US * `CLK_MHZ,  // 500us wait
  parameter int P_TXS_CYC     = 27,                        // self-refresh exit
  parameter int P_TMRD_CYC    = 4,                         // mrs to mrs
  parameter int P_TMOD_CYC    = 12,                        // mrs to non-mrs
  parameter int P_TDLLK_CYC   = 512,                       // dll lock
  parameter int P_TZQINIT_CYC = 512                        // zq init
) (
  input  wire logic        core_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  dpi_if.ctrl              mem
);

  ////////////////////////////////////////////////////////////////////////////
  // timing counts
  localparam int WARM_CYC = (`T_RST_WARM_NS * `CLK_MHZ + 999) / 1000;
  localparam int LEAD_CYC = (`T_CKE_LEAD_NS * `CLK_MHZ + 999) / 1000;
  localparam int HOLD_MIN = (WARM_CYC > LEAD_CYC) ? WARM_CYC : LEAD_CYC;
  localparam int XPR_CYC  = (P_TXS_CYC > `TXPR_MIN_TCK) ? P_TXS_CYC : `TXPR_MIN_TCK;
  localparam int LOCK_CYC = (P_TDLLK_CYC > P_TZQINIT_CYC) ? P_TDLLK_CYC : P_TZQINIT_CYC;

  // sequencer states
  typedef enum logic [3:0] {
    S_HOLD, S_WAIT, S_XPR, S_MRS, S_MRW, S_ZQ, S_LOCK, S_READY
  } dpi_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave
  logic        ack;                    // one-cycle answer
  logic [31:0] ctrl_reg;               // odt enable kept here
  logic [14:0] mr_val [4];             // application mode values
  logic [31:0] cmd_reg;                // user command fields
  logic        go_pend;                // start request
  logic        cmd_pend;               // user command waiting
  logic        first_pwr;              // first hold after power-up
  dpi_state_t  state;                  // sequencer state
  logic [16:0] cnt;                    // wait counter
  logic [1:0]  mr_step;                // 0:MR2 1:MR3 2:MR1 3:MR0
  dpi_state_t  next_state;             // state after this edge

  wire         req      = wb_cyc_i & wb_stb_i & ~ack;
  wire         wr       = req & wb_we_i;
  wire [31:0]  mask     = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                           {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [31:0]  wdat     = wb_dat_i & mask;
  wire         wr_ctrl  = wr & (wb_adr_i == `REG_CTRL);
  wire         wr_cmd   = wr & (wb_adr_i == `REG_CMD);
  wire         go_set   = wr_ctrl & wdat[`CTRL_GO_BIT];
  wire         warm_set = wr_ctrl & wdat[`CTRL_WARM_BIT];
  wire         ready    = (state == S_READY);
  wire [31:0]  status   = {24'h0, 4'(state), 2'h0, ~ready & ~(state == S_HOLD), ready};

  // read mux, unmapped reads zero
  wire [31:0] rdat =
    (wb_adr_i == `REG_CTRL)   ? ctrl_reg :
    (wb_adr_i == `REG_STATUS) ? status :
    (wb_adr_i == `REG_MR0)    ? {17'h0, mr_val[0]} :
    (wb_adr_i == `REG_MR1)    ? {17'h0, mr_val[1]} :
    (wb_adr_i == `REG_MR2)    ? {17'h0, mr_val[2]} :
    (wb_adr_i == `REG_MR3)    ? {17'h0, mr_val[3]} :
    (wb_adr_i == `REG_CMD)    ? cmd_reg : 32'h0;

  // ack and read data
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ack      <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      ack      <= req;
      wb_dat_o <= req ? rdat : 32'h0;
    end
  end
  assign wb_ack_o = ack;

  // mode value registers, one per mode register
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_mr
      always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          mr_val[gi] <= 15'h0;
        end else if (wr && wb_adr_i == 8'(`REG_MR0 + 4 * gi)) begin
          mr_val[gi] <= (mr_val[gi] & ~mask[14:0]) | wdat[14:0];
        end
      end
    end
  endgenerate

  // ctrl and command registers, pending flags (set wins)
  wire cmd_take = ready & cmd_pend;
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_reg <= 32'h0;
      cmd_reg  <= 32'h0;
      go_pend  <= 1'b0;
      cmd_pend <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= (ctrl_reg & ~mask) | (wdat & 32'h4);
      end
      if (wr_cmd && ready) begin
        cmd_reg <= (cmd_reg & ~mask) | wdat;
      end
      go_pend  <= go_set | (go_pend & ~(state == S_HOLD && next_state != S_HOLD));
      cmd_pend <= (wr_cmd & ready) | (cmd_pend & ~cmd_take);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer next state
  logic [16:0] next_cnt;
  logic [1:0]  next_mr_step;
  logic        next_first;
  logic        next_rst_n;
  logic        next_cke;
  logic        next_ck_run;
  logic [3:0]  next_cmd;
  logic [2:0]  next_ba;
  logic [14:0] next_a;

  wire [16:0] hold_lim = first_pwr ? 17'(P_RST_PWR_CYC) : 17'(HOLD_MIN);
  wire [1:0]  mr_idx   = (mr_step == 2'h0) ? 2'h2 :
                         (mr_step == 2'h1) ? 2'h3 :
                         (mr_step == 2'h2) ? 2'h1 : 2'h0;
  wire [2:0]  mr_ba    = (mr_step == 2'h0) ? `BA_MR2 :
                         (mr_step == 2'h1) ? `BA_MR3 :
                         (mr_step == 2'h2) ? `BA_MR1 : `BA_MR0;
  wire [14:0] mr_a     = (mr_step == 2'h2) ? (mr_val[1] & ~(15'h1 << `A_DLL_EN_BIT)) :
                         (mr_step == 2'h3) ? (mr_val[0] | (15'h1 << `A_DLL_RST_BIT)) :
                         mr_val[mr_idx];
  wire [16:0] mrw_lim  = (mr_step == 2'h3) ? 17'(P_TMOD_CYC) : 17'(P_TMRD_CYC);

  always_comb begin
    next_state   = state;
    next_cnt     = cnt + 17'h1;
    next_mr_step = mr_step;
    next_first   = first_pwr;
    next_rst_n   = 1'b1;
    next_cke     = 1'b1;
    next_ck_run  = 1'b1;
    next_cmd     = `CMD_NOP;
    next_ba      = 3'h0;
    next_a       = 15'h0;
    case (state)
      // reset low, cke low for the whole hold
      S_HOLD: begin
        next_rst_n = 1'b0;
        next_cke   = 1'b0;
        if (cnt >= hold_lim - 17'h1 && go_pend) begin
          next_state = S_WAIT;
          next_cnt   = 17'h0;
          next_first = 1'b0;
        end
      end
      // reset released, clock running, nop on the bus
      S_WAIT: begin
        next_cke = 1'b0;
        if (cnt == 17'(P_RST_CKE_CYC - 1)) begin
          next_state = S_XPR;
          next_cnt   = 17'h0;
        end
      end
      // cke up, wait before first mode load
      S_XPR: begin
        if (cnt == 17'(XPR_CYC - 1)) begin
          next_state   = S_MRS;
          next_mr_step = 2'h0;
        end
      end
      // issue one mode load in MR2, MR3, MR1, MR0 order
      S_MRS: begin
        next_cmd   = `CMD_MRS;
        next_ba    = mr_ba;
        next_a     = mr_a;
        next_cnt   = 17'h0;
        next_state = S_MRW;
      end
      // spacing after a mode load
      S_MRW: begin
        if (cnt == mrw_lim - 17'h1) begin
          if (mr_step == 2'h3) begin
            next_state = S_ZQ;
          end else begin
            next_state   = S_MRS;
            next_mr_step = mr_step + 2'h1;
          end
        end
      end
      // long calibration
      S_ZQ: begin
        next_cmd   = `CMD_ZQ;
        next_a     = 15'h1 << `A_AP_BIT;
        next_cnt   = 17'h0;
        next_state = S_LOCK;
      end
      // dll lock and zq init
      S_LOCK: begin
        if (cnt == 17'(LOCK_CYC - 1)) begin
          next_state = S_READY;
        end
      end
      // normal operation: pass user commands
      S_READY: begin
        next_cnt = 17'h0;
        if (cmd_pend) begin
          next_cmd = cmd_reg[3:0];
          next_ba  = cmd_reg[6:4];
          next_a   = cmd_reg[30:16];
        end
      end
      default: begin
        next_state = S_HOLD;
      end
    endcase
    if (warm_set) begin
      next_state = S_HOLD;
      next_cnt   = 17'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer and pin registers
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state      <= S_HOLD;
      cnt        <= 17'h0;
      mr_step    <= 2'h0;
      first_pwr  <= 1'b1;
      mem.reset_n <= 1'b0;
      mem.cke    <= 1'b0;
      mem.ck_run <= 1'b0;
      mem.cmd    <= `CMD_NOP;
      mem.ba     <= 3'h0;
      mem.a      <= 15'h0;
    end else begin
      state      <= next_state;
      cnt        <= next_cnt;
      mr_step    <= next_mr_step;
      first_pwr  <= next_first;
      mem.reset_n <= next_rst_n;
      mem.cke    <= (state == S_HOLD || state == S_WAIT) ? next_cke : 1'b1;
      mem.ck_run <= next_ck_run;
      mem.cmd    <= next_cmd;
      mem.ba     <= next_ba;
      mem.a      <= next_a;
    end
  end

  // odt low and static until ready
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mem.odt <= 1'b0;
    end else begin
      mem.odt <= ready & ctrl_reg[`CTRL_ODT_BIT];
    end
  end

endmodule

/* dpi_defs.svh */
// constants shared by both ends of the dram power-up link
`ifndef DPI_DEFS_SVH
`define DPI_DEFS_SVH
// clock rate and printed times
`define CLK_MHZ          100
`define T_RST_PWR_US     200
`define T_RST_WARM_NS    100
`define T_CKE_LEAD_NS    10
`define T_RST_CKE_US     500
`define TXPR_MIN_TCK     5
// command codes {cs_n, ras_n, cas_n, we_n}
`define CMD_MRS          4'h0
`define CMD_PRE          4'h2
`define CMD_ACT          4'h3
`define CMD_WR           4'h4
`define CMD_RD           4'h5
`define CMD_ZQ           4'h6
`define CMD_NOP          4'h7
`define CMD_DES          4'hf
// address bit positions
`define A_DLL_EN_BIT     0
`define A_DLL_RST_BIT    8
`define A_AP_BIT         10
`define A_BC_BIT         12
`define MR0_BL_LSB       0
`define MR0_BT_BIT       3
`define BL_OTF           2'h1
`define BL_BC4           2'h2
// mode register bank selects
`define BA_MR0           3'h0
`define BA_MR1           3'h1
`define BA_MR2           3'h2
`define BA_MR3           3'h3
// wishbone register byte offsets
`define REG_CTRL         8'h00
`define REG_STATUS       8'h04
`define REG_MR0          8'h08
`define REG_MR1          8'h0c
`define REG_MR2          8'h10
`define REG_MR3          8'h14
`define REG_CMD          8'h18
// ctrl bits
`define CTRL_GO_BIT      0
`define CTRL_WARM_BIT    1
`define CTRL_ODT_BIT     2
`endif

/* dpi_pkg.sv */
// shared types of the dram power-up link
`include "dpi_defs.svh"
package dpi_pkg;
  // command on the cs/ras/cas/we pins
  typedef enum logic [3:0] {
    DPI_MRS = `CMD_MRS,
    DPI_PRE = `CMD_PRE,
    DPI_ACT = `CMD_ACT,
    DPI_WR  = `CMD_WR,
    DPI_RD  = `CMD_RD,
    DPI_ZQ  = `CMD_ZQ,
    DPI_NOP = `CMD_NOP,
    DPI_DES = `CMD_DES
  } dpi_cmd_t;
endpackage

/* dpi_if.sv */
// command/address link between controller and dram
`timescale 1ns/1ps
interface dpi_if;
  logic        reset_n;  // active-low dram reset
  logic        cke;      // clock enable
  logic        ck_run;   // ck running and stable
  logic [3:0]  cmd;      // {cs_n, ras_n, cas_n, we_n}
  logic [2:0]  ba;       // bank address
  logic [14:0] a;        // address / opcode
  logic        odt;      // termination request
  modport ctrl (output reset_n, cke, ck_run, cmd, ba, a, odt);
  modport dram (input reset_n, cke, ck_run, cmd, ba, a, odt);
endinterface

/* dpi_dram.sv */
// dram end: bank state, burst addressing and init tracking
`timescale 1ns/1ps
`include "dpi_defs.svh"
module dpi_dram
  import dpi_pkg::*;
#(
  parameter int P_COLBITS = 10,   // column address bits
  parameter int P_ORG     = 8     // dq width
) (
  input  wire logic        core_clk_i,
  input  wire logic        rst_b_i,
  dpi_if.dram              mem,
  output logic             init_done_o,
  output logic             odt_on_o,
  output logic [7:0]       bank_open_o,
  output logic             burst_busy_o,
  output logic             burst_rd_o,
  output logic             burst_chop_o,
  output logic             burst_ap_o,
  output logic [2:0]       burst_bank_o,
  output logic [14:0]      burst_row_o,
  output logic [9:0]       beat_col0_o,
  output logic [9:0]       beat_col1_o,
  output logic [31:0]      page_bytes_o
);

  ////////////////////////////////////////////////////////////////////////////
  // decode
  localparam int PAGE_BYTES = (1 << P_COLBITS) * P_ORG / 8;

  dpi_cmd_t cmd_q;
  assign cmd_q = dpi_cmd_t'(mem.cmd);
  wire in_rst   = ~mem.reset_n;
  wire live     = mem.reset_n & mem.ck_run & mem.cke;
  wire is_act   = live & (cmd_q == DPI_ACT);
  wire is_pre   = live & (cmd_q == DPI_PRE);
  wire is_rw    = live & ((cmd_q == DPI_RD) | (cmd_q == DPI_WR));
  wire is_mrs   = live & (cmd_q == DPI_MRS);
  wire is_zq    = live & (cmd_q == DPI_ZQ);
  wire pre_all  = mem.a[`A_AP_BIT];

  logic [1:0]  bl_mode;               // MR0 burst length field
  logic        bt_il;                 // interleaved order
  logic        cke_seen;              // cke registered high
  logic [3:0]  mr_seen;               // mode loads seen
  logic        zq_seen;               // long calibration seen
  logic [14:0] row [8];               // open row per bank
  logic [7:0]  open;                  // bank active
  logic [2:0]  beat;                  // burst beat index
  logic [9:0]  col_st;                // burst start column
  logic        end_burst;             // last clock of burst

  // chop from A12 only in on-the-fly mode, else fixed setting
  wire chop = (bl_mode == `BL_OTF) ? ~mem.a[`A_BC_BIT] : (bl_mode == `BL_BC4);
  wire [2:0] last_beat = burst_chop_o ? 3'h2 : 3'h6;
  assign end_burst = burst_busy_o & (beat == last_beat);

  // burst order of beat i from start column
  function automatic logic [9:0] order(input logic [9:0] st, input logic [2:0] i,
                                       input logic il);
    logic [2:0] lo;
    lo = il ? (st[2:0] ^ i) : {st[2] ^ i[2], st[1:0] + i[1:0]};
    return {st[9:3], lo};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // init tracking, cleared by reset independent of clock count
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cke_seen <= 1'b0;
      mr_seen  <= 4'h0;
      zq_seen  <= 1'b0;
      bl_mode  <= 2'h0;
      bt_il    <= 1'b0;
    end else if (in_rst) begin
      cke_seen <= 1'b0;
      mr_seen  <= 4'h0;
      zq_seen  <= 1'b0;
    end else begin
      cke_seen <= cke_seen | (mem.ck_run & mem.cke);
      if (is_mrs) begin
        mr_seen[mem.ba[1:0]] <= 1'b1;
      end
      if (is_mrs && mem.ba == `BA_MR0) begin
        bl_mode <= mem.a[`MR0_BL_LSB +: 2];
        bt_il   <= mem.a[`MR0_BT_BIT];
      end
      zq_seen <= zq_seen | (is_zq & (&mr_seen));
    end
  end
  assign init_done_o = zq_seen;

  // termination high impedance until cke registered
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      odt_on_o <= 1'b0;
    end else begin
      odt_on_o <= ~in_rst & cke_seen & mem.odt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // eight banks, each opened and closed on its own, or all closed together by precharge with A10 high
  genvar gb;
  generate
    for (gb = 0; gb < 8; gb++) begin : g_bank
      wire sel = (mem.ba == 3'(gb));
      wire ap_close = end_burst & burst_ap_o & (burst_bank_o == 3'(gb));
      always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          open[gb] <= 1'b0;
          row[gb]  <= 15'h0;
        end else if (in_rst) begin
          open[gb] <= 1'b0;
        end else if (is_act && sel) begin
          open[gb] <= 1'b1;
          row[gb]  <= mem.a;
        end else if ((is_pre && (pre_all || sel)) || ap_close) begin
          open[gb] <= 1'b0;
        end
      end
    end
  endgenerate
  assign bank_open_o = open;

  ////////////////////////////////////////////////////////////////////////////
  // burst: two beats per clock, four clocks for eight beats
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      burst_busy_o <= 1'b0;
      burst_rd_o   <= 1'b0;
      burst_chop_o <= 1'b0;
      burst_ap_o   <= 1'b0;
      burst_bank_o <= 3'h0;
      burst_row_o  <= 15'h0;
      col_st       <= 10'h0;
      beat         <= 3'h0;
    end else if (in_rst) begin
      burst_busy_o <= 1'b0;
    end else if (is_rw && open[mem.ba]) begin
      burst_busy_o <= 1'b1;
      burst_rd_o   <= (cmd_q == DPI_RD);
      burst_chop_o <= chop;
      burst_ap_o   <= mem.a[`A_AP_BIT];
      burst_bank_o <= mem.ba;
      burst_row_o  <= row[mem.ba];
      col_st       <= mem.a[9:0];
      beat         <= 3'h0;
    end else if (end_burst) begin
      burst_busy_o <= 1'b0;
    end else if (burst_busy_o) begin
      beat <= beat + 3'h2;
    end
  end

  // column pair of the current clock
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      beat_col0_o <= 10'h0;
      beat_col1_o <= 10'h0;
    end else begin
      beat_col0_o <= order(col_st, beat, bt_il);
      beat_col1_o <= order(col_st, beat + 3'h1, bt_il);
    end
  end
  assign page_bytes_o = 32'(PAGE_BYTES);

endmodule

/* dpi_checker.sv */
// link checker for the power-up sequence between controller and dram
`timescale 1ns/1ps
module dpi_checker
  import dpi_pkg::*;
#(
  parameter int P_RST_CKE_CYC = 20,  // release to cke wait
  parameter int P_TXPR_CYC    = 27,  // cke to first mode load
  parameter int P_ZQ_CYC      = 16   // lock and calibration wait
) (
  input  wire logic        core_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        reset_n,
  input  wire logic        cke,
  input  wire logic        ck_run,
  input  wire logic [3:0]  cmd,
  input  wire logic [2:0]  ba,
  input  wire logic [14:0] a,
  input  wire logic        odt
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  ////////////////////////////////////////////////////////////////////////////////
  logic [15:0] low_cnt;   // cycles with dram reset low
  logic [15:0] wait_cnt;  // cycles released with cke low
  logic [15:0] cke_cnt;   // cycles with cke high
  logic [15:0] zq_cnt;    // cycles since long calibration
  logic [2:0]  mrs_cnt;   // mode loads seen
  logic        zq_seen;   // long calibration issued
  wire logic   idle_cmd = (cmd == DPI_NOP) || (cmd == DPI_DES);  // nop or deselect
  wire logic   mrs_go   = cke && (cmd == DPI_MRS);               // mode load
  wire logic   zq_go    = cke && (cmd == DPI_ZQ);                // calibration
  // expected bank select per load slot
  wire logic [2:0] exp_ba = (mrs_cnt == 3'h0) ? 3'h2 : (mrs_cnt == 3'h1) ? 3'h3 :
                            (mrs_cnt == 3'h2) ? 3'h1 : 3'h0;
  // interval counters
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      low_cnt  <= '0;
      wait_cnt <= '0;
      cke_cnt  <= '0;
    end else begin
      low_cnt  <= reset_n ? '0 : low_cnt + 16'h1;
      wait_cnt <= !reset_n ? '0 : wait_cnt + {15'h0, !cke};
      cke_cnt  <= cke ? cke_cnt + 16'h1 : '0;
    end
  end
  // init progress tracking
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mrs_cnt <= '0;
      zq_seen <= 1'b0;
      zq_cnt  <= '0;
    end else begin
      mrs_cnt <= !reset_n ? '0 : mrs_cnt + {2'h0, mrs_go && (mrs_cnt < 3'h4)};
      zq_seen <= reset_n && (zq_seen || zq_go);
      zq_cnt  <= zq_go ? 16'h1 : (zq_seen ? zq_cnt + 16'h1 : '0);
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_cke_in_reset: assert property (!reset_n |-> !cke)
    else $error("cke high while dram reset low");
  a_reset_hold: assert property ($rose(reset_n) |-> low_cnt >= 16'd10)
    else $error("dram reset released too early");
  a_cke_wait: assert property ($rose(cke) |-> wait_cnt >= P_RST_CKE_CYC)
    else $error("cke raised before release wait ended");
  a_clk_before_cke: assert property ($rose(cke) |-> ck_run && $past(ck_run, 5))
    else $error("clock not stable before cke");
  a_nop_before_cke: assert property ($rose(cke) |-> $past(idle_cmd))
    else $error("no idle command before cke");
  a_cke_held: assert property ($fell(cke) |-> !reset_n)
    else $error("cke dropped outside reset");
  a_odt_quiet: assert property (zq_cnt < P_ZQ_CYC |-> !odt)
    else $error("odt moved during init");
  a_txpr_wait: assert property (mrs_go && mrs_cnt == 3'h0 |-> cke_cnt >= P_TXPR_CYC)
    else $error("first mode load too soon");
  a_mrs_order: assert property (mrs_go && mrs_cnt < 3'h4 |-> ba == exp_ba)
    else $error("mode loads out of order");
  a_dll_bits: assert property (mrs_go && mrs_cnt[1] |-> (mrs_cnt[0] ? a[8] : !a[0]))
    else $error("dll enable or reset bit wrong");
  a_zq_after_mr: assert property (zq_go |-> mrs_cnt == 3'h4 && a[10])
    else $error("calibration not long or too early");
  a_nop_between: assert property (!zq_seen && !mrs_go && !zq_go |-> idle_cmd)
    else $error("command during init wait");
  c_cke_up: cover property ($rose(cke));
  c_zq: cover property (zq_go);
  c_warm: cover property ($rose(reset_n) && low_cnt < 16'd20);
endmodule

/* tb_top.sv */
// bench joining controller and dram, driven over wishbone
`timescale 1ns/1ps
`include "dpi_defs.svh"
module tb_top;
  logic        clk;       // core clock
  logic        rst_b;     // core reset
  logic        cyc;       // wishbone cycle
  logic        stb;       // wishbone strobe
  logic        we;        // write enable
  logic [7:0]  adr;       // byte address
  logic [3:0]  sel;       // byte enables
  logic [31:0] wdat;      // write data
  logic [31:0] rdat;      // read data
  logic        ack;       // acknowledge
  logic        done;      // dram init finished
  logic        odt_on;    // termination active
  logic [7:0]  bank_open; // open banks
  logic        busy;      // burst running
  logic        rd;        // burst is read
  logic        chop;      // burst chopped
  logic        ap;        // auto precharge
  logic [2:0]  bank;      // burst bank
  logic [14:0] row;       // burst row
  logic [9:0]  col0;      // even beat column
  logic [9:0]  col1;      // odd beat column
  logic [31:0] page;      // page bytes
  logic [31:0] q;         // last read word
  int          mismatches;
  int          n_tests;
  ////////////////////////////////////////////////////////////////////////////////
  dpi_if mem_i ();
  dpi_ctrl #(.P_RST_PWR_CYC(20), .P_RST_CKE_CYC(20), .P_TDLLK_CYC(16), .P_TZQINIT_CYC(16))
    dpi_ctrl_i (.core_clk_i(clk), .rst_b_i(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .mem(mem_i));
  dpi_dram dpi_dram_i (.core_clk_i(clk), .rst_b_i(rst_b), .mem(mem_i), .init_done_o(done),
    .odt_on_o(odt_on), .bank_open_o(bank_open), .burst_busy_o(busy), .burst_rd_o(rd),
    .burst_chop_o(chop), .burst_ap_o(ap), .burst_bank_o(bank), .burst_row_o(row),
    .beat_col0_o(col0), .beat_col1_o(col1), .page_bytes_o(page));
  dpi_checker dpi_checker_i (
    .core_clk_i(clk), .rst_b_i(rst_b), .reset_n(mem_i.reset_n), .cke(mem_i.cke),
    .ck_run(mem_i.ck_run), .cmd(mem_i.cmd), .ba(mem_i.ba), .a(mem_i.a), .odt(mem_i.odt));
  ////////////////////////////////////////////////////////////////////////////////
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one classic wishbone cycle, read word left in q
  task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, ad, 4'hf, d};
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    {cyc, stb} <= 2'b00;
  endtask
  // command through the command register
  task automatic cmdw(input logic [3:0] c, input logic [2:0] b, input logic [14:0] ad);
    wb(1'b1, `REG_CMD, {1'b0, ad, 9'h0, b, c});
  endtask
  // poll status until the given state
  task automatic wait_state(input logic [3:0] st);
    do begin
      wb(1'b0, `REG_STATUS, 32'h0);
    end while (q[7:4] !== st);
  endtask
  // expected beat column
  function automatic logic [9:0] col(input logic [9:0] s, input int i, input logic bt);
    logic [2:0] b;
    b = bt ? (s[2:0] ^ i[2:0]) : {s[2] ^ i[2], s[1:0] + i[1:0]};
    return {s[9:3], b};
  endfunction
  // burst to bank 5 row 1234, then check flags and beat order
  task automatic burst(input logic [3:0] c, input logic [14:0] ad, input logic bt);
    cmdw(c, 3'h5, ad);
    #1;
    while (busy !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    chk({rd, chop, ap, bank}, {c == `CMD_RD, !ad[12], ad[10], 3'h5}, "burst flags");
    chk(row, 15'h1234, "burst row");
    for (int i = 0; i < (ad[12] ? 8 : 4); i += 2) begin
      @(posedge clk);
      #1;
      chk({col0, col1}, {col(ad[9:0], i, bt), col(ad[9:0], i + 1, bt)}, "beats");
    end
    chk(busy, 1'b0, "burst end");
    repeat (6) @(posedge clk);
  endtask
  // verdict
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    conclude;
  end
  // main sequence
  initial begin
    {cyc, stb, we, adr, sel, wdat, rst_b} = '0;
    mismatches = 0;
    n_tests = 0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    chk(page, 32'h400, "page size");
    wb(1'b1, `REG_MR0, 32'h1);
    wb(1'b1, `REG_MR1, 32'h4);
    wb(1'b0, 8'h1c, 32'h0);
    chk(q, 32'h0, "unmapped read");
    wb(1'b1, `REG_CTRL, 32'h5);
    wait_state(4'h1);
    chk({done, odt_on}, 2'b00, "odt in wait");
    wait_state(4'h7);
    chk(done, 1'b1, "init done");
    cmdw(`CMD_ACT, 3'h5, 15'h1234);
    repeat (4) @(posedge clk);
    chk(bank_open, 8'h20, "activate");
    chk(odt_on, 1'b1, "odt after init");
    burst(`CMD_RD, 15'h1005, 1'b0);
    burst(`CMD_WR, 15'h0403, 1'b0);
    chk(bank_open, 8'h00, "auto precharge");
    cmdw(`CMD_ACT, 3'h2, 15'h0);
    cmdw(`CMD_ACT, 3'h3, 15'h0);
    cmdw(`CMD_PRE, 3'h2, 15'h0);
    repeat (4) @(posedge clk);
    chk(bank_open, 8'h08, "precharge one");
    cmdw(`CMD_PRE, 3'h0, 15'h0400);
    repeat (4) @(posedge clk);
    chk(bank_open, 8'h00, "precharge all");
    cmdw(`CMD_ACT, 3'h5, 15'h1234);
    wb(1'b1, `REG_MR0, 32'h9);
    wb(1'b1, `REG_CTRL, 32'h2);
    wb(1'b1, `REG_CTRL, 32'h5);
    wait_state(4'h7);
    chk({done, bank_open}, 9'h100, "warm reset");
    cmdw(`CMD_ACT, 3'h5, 15'h1234);
    repeat (4) @(posedge clk);
    burst(`CMD_RD, 15'h1005, 1'b1);
    conclude;
  end
endmodule
